// ===== rtl/qdsl_host.sv
`timescale 1ns/100ps

// Notes on behaviour
// - word is address, two pad, 12-bit code
// - address first, then pad, code MSB first
// - raise chip select only while clock high
// - load strobe high while shifting, pulse afterwards
// - select pin settles 25 ns before reset
// - keep chip select high when idle
module qdsl_host (
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire logic                         req_valid,
  input  wire qdsl_pkg::qdsl_op_t           req_op,
  input  wire logic [qdsl_pkg::ADDR_BITS-1:0] req_channel,
  input  wire logic [qdsl_pkg::CODE_BITS-1:0] req_code,
  input  wire logic                         req_reset_sel,
  output logic                              req_ready,
  output logic                              req_done,
  output logic                              dac_sclk,
  output logic                              dac_cs_n,
  output logic                              serial_data_in,
  output logic                              input_load_strobe_n,
  output logic                              dac_load_strobe_n,
  output logic                              dac_reset_n,
  output logic                              reset_code_select
);
  import qdsl_pkg::*;

  // sequencer state, wait count, bits left, outgoing word
  qdsl_state_t                state_reg, state_next;
  logic [CNT_W-1:0]           cnt_reg,   cnt_next;
  logic [BIT_CNT_W-1:0]       bit_reg,   bit_next;
  logic [WORD_BITS-1:0]       shift_reg, shift_next;

  // handshake and pin flops
  logic                       ready_reg, ready_next;
  logic                       done_reg,  done_next;
  logic                       sclk_reg,  sclk_next;
  logic                       cs_n_reg,  cs_n_next;
  logic                       sdi_reg,   sdi_next;
  logic                       ldreg_reg, ldreg_next;
  logic                       lddac_reg, lddac_next;
  logic                       rst_n_reg, rst_n_next;
  logic                       rsel_reg,  rsel_next;

  // a busy state waits its reload count plus one cycle,
  // then acts once; idle acts only on an accepted request
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    ready_next = ready_reg;
    done_next  = 1'b0;
    sclk_next  = sclk_reg;
    cs_n_next  = cs_n_reg;
    sdi_next   = sdi_reg;
    ldreg_next = ldreg_reg;
    lddac_next = lddac_reg;
    rst_n_next = rst_n_reg;
    rsel_next  = rsel_reg;
    if (state_reg != ST_IDLE && cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          // requests while busy are dropped, not queued
          if (req_valid && ready_reg) begin
            ready_next = 1'b0;
            unique case (req_op)
              QDSL_OP_WRITE: begin
                // address, pad, code, sent from the top bit down
                shift_next = {req_channel, PAD_BITS, req_code};
                sdi_next   = req_channel[ADDR_BITS-1];
                bit_next   = LAST_BIT_IDX;
                cs_n_next  = 1'b0;
                sclk_next  = 1'b0;
                cnt_next   = N_FIRST;
                state_next = ST_LOW;
              end
              QDSL_OP_UPDATE: begin
                lddac_next = 1'b0;
                cnt_next   = N_LDDW;
                state_next = ST_LDDAC;
              end
              default: begin
                // select pin settles before reset falls
                rsel_next  = req_reset_sel;
                cnt_next   = N_RSSH;
                state_next = ST_RSSH;
              end
            endcase
          end
        end
        ST_LOW: begin
          // rising edge shifts one bit into the device
          sclk_next  = 1'b1;
          cnt_next   = N_HIGH;
          state_next = ST_HIGH;
        end
        ST_HIGH: begin
          if (bit_reg == '0) begin
            // clock stays high so chip select rises without an edge
            cnt_next   = N_CSH;
            state_next = ST_CSH;
          end else begin
            // falling edge moves the next bit out
            sclk_next  = 1'b0;
            shift_next = {shift_reg[WORD_BITS-2:0], 1'b0};
            sdi_next   = shift_reg[WORD_BITS-2];
            bit_next   = bit_reg - 1'b1;
            cnt_next   = N_LOW;
            state_next = ST_LOW;
          end
        end
        ST_CSH: begin
          cs_n_next  = 1'b1;
          // exactly sixteen edges, so no extra bits to displace the word
          ldreg_next = 1'b0;
          cnt_next   = N_LDRW;
          state_next = ST_LDREG;
        end
        ST_LDREG: begin
          // clock may drop now, chip select high masks it
          sclk_next  = 1'b0;
          ldreg_next = 1'b1;
          cnt_next   = N_LD1;
          state_next = ST_LD1;
        end
        ST_LD1: begin
          // strobe high well ahead of the next first edge
          ready_next = 1'b1;
          done_next  = 1'b1;
          state_next = ST_IDLE;
        end
        ST_LDDAC: begin
          // all four outputs moved together on the strobe fall
          lddac_next = 1'b1;
          ready_next = 1'b1;
          done_next  = 1'b1;
          state_next = ST_IDLE;
        end
        ST_RSSH: begin
          // select has settled, pull reset low
          rst_n_next = 1'b0;
          cnt_next   = N_RSTW;
          state_next = ST_RST;
        end
        ST_RST: begin
          // holding registers keep the reset code
          rst_n_next = 1'b1;
          ready_next = 1'b1;
          done_next  = 1'b1;
          state_next = ST_IDLE;
        end
        default: begin
          // illegal code, recover to idle
          state_next = ST_IDLE;
          ready_next = 1'b1;
        end
      endcase
    end
  end

  // every output is one of these flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      bit_reg   <= '0;
      shift_reg <= '0;
      ready_reg <= 1'b1;
      done_reg  <= 1'b0;
      sclk_reg  <= 1'b0;
      cs_n_reg  <= 1'b1;
      sdi_reg   <= 1'b0;
      ldreg_reg <= 1'b1;
      lddac_reg <= 1'b1;
      rst_n_reg <= 1'b1;
      rsel_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      ready_reg <= ready_next;
      done_reg  <= done_next;
      sclk_reg  <= sclk_next;
      cs_n_reg  <= cs_n_next;
      sdi_reg   <= sdi_next;
      ldreg_reg <= ldreg_next;
      lddac_reg <= lddac_next;
      rst_n_reg <= rst_n_next;
      rsel_reg  <= rsel_next;
    end
  end

  // idle: chip select high, clock low, strobes high
  assign req_ready           = ready_reg;
  assign req_done            = done_reg;
  assign dac_sclk            = sclk_reg;
  assign dac_cs_n            = cs_n_reg;
  assign serial_data_in      = sdi_reg;
  assign input_load_strobe_n = ldreg_reg;
  assign dac_load_strobe_n   = lddac_reg;
  assign dac_reset_n         = rst_n_reg;
  assign reset_code_select   = rsel_reg;

endmodule : qdsl_host

// ===== rtl/qdsl_pkg.sv
package qdsl_pkg;

  // timing base
  localparam int CLK_PERIOD_PS = 4000;

  // least times at the converter pins, in ns
  localparam int T_DS_NS   = 25;
  localparam int T_DH_NS   = 20;
  localparam int T_CH_NS   = 30;
  localparam int T_CL_NS   = 50;
  localparam int T_CSS_NS  = 55;
  localparam int T_CSH_NS  = 15;
  localparam int T_LD1_NS  = 40;
  localparam int T_LD2_NS  = 15;
  localparam int T_LDRW_NS = 45;
  localparam int T_LDDW_NS = 45;
  localparam int T_RSSH_NS = 25;
  localparam int T_RSTW_NS = 70;

  // least time rounded up to whole cycles, never below one
  function automatic int qdsl_ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : qdsl_ns_to_cyc

  function automatic int qdsl_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : qdsl_max

  localparam int CYC_LOW   = qdsl_max(qdsl_ns_to_cyc(T_CL_NS), qdsl_ns_to_cyc(T_DS_NS));
  localparam int CYC_HIGH  = qdsl_max(qdsl_max(qdsl_ns_to_cyc(T_CH_NS),
                                               qdsl_ns_to_cyc(T_DH_NS)),
                                      qdsl_ns_to_cyc(T_LD2_NS));
  localparam int CYC_FIRST = qdsl_max(qdsl_ns_to_cyc(T_CSS_NS), CYC_LOW);
  localparam int CYC_CSH   = qdsl_ns_to_cyc(T_CSH_NS);
  localparam int CYC_LDRW  = qdsl_ns_to_cyc(T_LDRW_NS);
  localparam int CYC_LD1   = qdsl_ns_to_cyc(T_LD1_NS);
  localparam int CYC_LDDW  = qdsl_ns_to_cyc(T_LDDW_NS);
  localparam int CYC_RSSH  = qdsl_ns_to_cyc(T_RSSH_NS);
  localparam int CYC_RSTW  = qdsl_ns_to_cyc(T_RSTW_NS);

  // word layout
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 2;
  localparam int CODE_BITS = 12;
  localparam logic [1:0] PAD_BITS = 2'h0;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT_IDX = 4'hf;

  // wait counter reload values (state held count+1 cycles)
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] N_FIRST = CNT_W'(CYC_FIRST - 1);
  localparam logic [CNT_W-1:0] N_LOW   = CNT_W'(CYC_LOW - 1);
  localparam logic [CNT_W-1:0] N_HIGH  = CNT_W'(CYC_HIGH - 1);
  localparam logic [CNT_W-1:0] N_CSH   = CNT_W'(CYC_CSH - 1);
  localparam logic [CNT_W-1:0] N_LDRW  = CNT_W'(CYC_LDRW - 1);
  localparam logic [CNT_W-1:0] N_LD1   = CNT_W'(CYC_LD1 - 1);
  localparam logic [CNT_W-1:0] N_LDDW  = CNT_W'(CYC_LDDW - 1);
  localparam logic [CNT_W-1:0] N_RSSH  = CNT_W'(CYC_RSSH - 1);
  localparam logic [CNT_W-1:0] N_RSTW  = CNT_W'(CYC_RSTW - 1);

  typedef enum logic [1:0] {
    QDSL_OP_WRITE,
    QDSL_OP_UPDATE,
    QDSL_OP_RESET
  } qdsl_op_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH,
    ST_CSH,
    ST_LDREG,
    ST_LD1,
    ST_LDDAC,
    ST_RSSH,
    ST_RST
  } qdsl_state_t;

endpackage : qdsl_pkg

// ===== dv/qdsl_monitor.sv
`timescale 1ns/100ps
module qdsl_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_done,
  input wire logic dac_sclk,
  input wire logic dac_cs_n,
  input wire logic serial_data_in,
  input wire logic input_load_strobe_n,
  input wire logic dac_load_strobe_n,
  input wire logic dac_reset_n,
  input wire logic reset_code_select
);
  logic [4:0] edges_reg;
  logic [4:0] edges_next;
  logic       sclk_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // rising serial clock edges inside one frame
  always_comb begin
    edges_next = edges_reg;
    if (dac_cs_n) edges_next = 5'h0;
    else if (dac_sclk && !sclk_reg) edges_next = edges_reg + 5'h1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edges_reg <= 5'h0;
      sclk_reg  <= 1'b0;
    end else begin
      edges_reg <= edges_next;
      sclk_reg  <= dac_sclk;
    end
  end
  a_edge_count: assert property ($rose(dac_cs_n) |-> edges_reg == 5'h10)
    else $error("frame did not carry sixteen clock edges");
  a_cs_rise_high: assert property ($rose(dac_cs_n) |-> dac_sclk && $past(dac_sclk))
    else $error("chip select rose with serial clock low");
  a_sdi_held: assert property ($rose(dac_sclk) |-> $stable(serial_data_in)[*6])
    else $error("serial data moved around clock edge");
  a_shift_no_load: assert property ($rose(dac_sclk) |->
    input_load_strobe_n && $past(input_load_strobe_n, 10))
    else $error("load strobe not high long enough before clock");
  a_load_cs_idle: assert property (!input_load_strobe_n |-> dac_cs_n)
    else $error("load strobe low while selected");
  a_load_width: assert property ($fell(input_load_strobe_n) |-> !input_load_strobe_n[*8]
    ##1 !input_load_strobe_n[*4] ##1 input_load_strobe_n ##10 req_done)
    else $error("input load pulse width or done wrong");
  a_update_width: assert property ($fell(dac_load_strobe_n) |-> !dac_load_strobe_n[*8]
    ##1 !dac_load_strobe_n[*4] ##1 dac_load_strobe_n && req_done)
    else $error("dac load pulse width wrong");
  a_reset_width: assert property ($fell(dac_reset_n) |-> !dac_reset_n[*8]
    ##1 !dac_reset_n[*8] ##1 !dac_reset_n[*2] ##1 dac_reset_n)
    else $error("device reset pulse width wrong");
  a_sel_setup: assert property ($fell(dac_reset_n) |->
    $past(reset_code_select, 7) == reset_code_select)
    else $error("reset code select not settled before reset");
endmodule : qdsl_monitor
bind qdsl_host qdsl_monitor i_mon (.clk, .resetn, .req_done, .dac_sclk, .dac_cs_n,
  .serial_data_in, .input_load_strobe_n, .dac_load_strobe_n, .dac_reset_n,
  .reset_code_select);

// ===== dv/qdsl_dev_model.sv
`timescale 1ns/100ps
module qdsl_dev_model (
  input  wire logic             dac_sclk,
  input  wire logic             dac_cs_n,
  input  wire logic             serial_data_in,
  input  wire logic             input_load_strobe_n,
  input  wire logic             dac_load_strobe_n,
  input  wire logic             dac_reset_n,
  input  wire logic             reset_code_select,
  output logic      [3:0][11:0] dac_val
);
  logic [15:0]      sr;
  logic [3:0][11:0] in_reg;
  wire  [11:0]      rc = reset_code_select ? 12'h800 : 12'h000;
  // either pin may clock the shift register
  wire              sh_clk = dac_cs_n | dac_sclk;
  // reset leaves the shift register alone
  always @(posedge sh_clk) sr <= {sr[14:0], serial_data_in};
  always @* begin
    if (!dac_reset_n) in_reg = {4{rc}};
    else if (!input_load_strobe_n) in_reg[sr[15:14]] = sr[11:0];
  end
  always @* begin
    if (!dac_reset_n) dac_val = {4{rc}};
    else if (!dac_load_strobe_n) dac_val = in_reg;
  end
endmodule : qdsl_dev_model

// ===== dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import qdsl_pkg::*;
  logic             clk = 1'b0;
  logic             resetn = 1'b0;
  logic             req_valid = 1'b0;
  qdsl_op_t         req_op = QDSL_OP_WRITE;
  logic [1:0]       req_channel = 2'h0;
  logic [11:0]      req_code = 12'h000;
  logic             req_reset_sel = 1'b0;
  logic             req_ready, req_done, dac_sclk, dac_cs_n, serial_data_in;
  logic             input_load_strobe_n, dac_load_strobe_n, dac_reset_n, reset_code_select;
  logic [3:0][11:0] dac_val, exp_val;
  logic [3:0][11:0] codes = {12'hfff, 12'h001, 12'h800, 12'ha5c};
  int               errors = 0;
  int               total_checks = 0;
  always #2 clk = ~clk;
  qdsl_host i_dut (.clk, .resetn, .req_valid, .req_op, .req_channel, .req_code,
    .req_reset_sel, .req_ready, .req_done, .dac_sclk, .dac_cs_n, .serial_data_in,
    .input_load_strobe_n, .dac_load_strobe_n, .dac_reset_n, .reset_code_select);
  qdsl_dev_model i_dev (.dac_sclk, .dac_cs_n, .serial_data_in, .input_load_strobe_n,
    .dac_load_strobe_n, .dac_reset_n, .reset_code_select, .dac_val);
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // one request, with a stray update offered while busy
  task automatic do_op(input qdsl_op_t op, input logic [1:0] ch, input logic [11:0] code,
                       input logic sel, input int lat);
    int n;
    n = -1;
    req_op = op;
    req_channel = ch;
    req_code = code;
    req_reset_sel = sel;
    req_valid = 1'b1;
    do begin
      @(posedge clk);
      #1;
      n++;
      req_valid = (n == 5);
      if (n == 5) req_op = QDSL_OP_UPDATE;
    end while (req_done !== 1'b1 && n < 500);
    check("latency", 48'(n), 48'(lat));
  endtask : do_op
  task automatic t_reset(input logic sel);
    do_op(QDSL_OP_RESET, 2'h0, 12'h000, sel, 25);
    exp_val = {4{sel ? 12'h800 : 12'h000}};
    check("dac after reset", dac_val, exp_val);
    check("input after reset", i_dev.in_reg, exp_val);
  endtask : t_reset
  task automatic t_write_all;
    for (int ch = 0; ch < 4; ch++) begin
      do_op(QDSL_OP_WRITE, 2'(ch), codes[ch], 1'b0, 363);
      check("shift word", i_dev.sr, {2'(ch), 2'h0, codes[ch]});
      check("input reg", i_dev.in_reg[ch], codes[ch]);
      check("dac held", dac_val, 48'h0);
    end
    do_op(QDSL_OP_UPDATE, 2'h0, 12'h000, 1'b0, 12);
    check("dac updated", dac_val, codes);
  endtask : t_write_all
  task automatic t_reset_keep;
    do_op(QDSL_OP_WRITE, 2'h2, 12'h3c3, 1'b0, 363);
    t_reset(1'b1);
    check("shift kept", i_dev.sr, 48'h83c3);
    do_op(QDSL_OP_WRITE, 2'h1, 12'h5a5, 1'b0, 363);
    check("dac keeps reset", dac_val, {4{12'h800}});
    t_reset(1'b0);
  endtask : t_reset_keep
  initial begin
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    check("idle pins", {req_ready, req_done, dac_sclk, dac_cs_n, serial_data_in,
      input_load_strobe_n, dac_load_strobe_n, dac_reset_n, reset_code_select}, 9'h12e);
    t_reset(1'b0);
    t_write_all();
    t_reset_keep();
    report_and_stop();
  end
  initial begin
    #40000;
    errors++;
    report_and_stop();
  end
endmodule : testbench
